/* bench/feg_gate_monitor.sv */
// concurrent checks of the exception-gating unit at its ports
`default_nettype none
module feg_gate_monitor
    import feg_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire logic                instr_valid,
    input wire feg_pkg::feg_instr_t instr,
    input wire logic                instr_ack,
    input wire logic                instr_trap,
    input wire logic                instr_is_arith,
    input wire logic                exc_valid,
    input wire feg_pkg::feg_exc_t   exc,
    input wire logic                top_hold,
    input wire logic                store_valid,
    input wire logic [31:0]         store_data,
    input wire logic [15:0]         status_word,
    input wire logic [15:0]         control_word,
    input wire logic                irq
);
    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // pending unmasked set, the legacy codes that never wait and the non-waiting forms
    wire logic pend    = |(status_word[5:0] & ~control_word[5:0]);
    wire logic legacy  = instr.op inside {legacy_enable_irq_op, legacy_disable_irq_op,
                                          legacy_set_protmode_op};
    wire logic nw_form = instr.nowait && (instr.op inside {store_status_word_op,
        store_control_word_op, clear_exceptions_op, initialize_op, full_state_save_op,
        store_environment_op});
    a_gate_answer: assert property (
        instr_valid && !instr_ack && !instr_trap |=> ((instr_ack ^ instr_trap)
        && instr_trap == $past(pend && !legacy && !nw_form)))
        else $error("answer wrong");
    a_summary_flag: assert property (
        $stable(status_word[5:0]) && $stable(control_word[5:0]) |-> status_word[7] == pend)
        else $error("summary flag wrong");
    a_stack_fault: assert property (exc_valid && exc.stack_fault |=>
        status_word[0] && status_word[6] && status_word[9] == $past(exc.stack_overflow))
        else $error("stack fault bits wrong");
    a_hold_cause: assert property (
        top_hold |-> $past(exc_valid) && !$past(control_word[0]))
        else $error("stray top hold");
    a_hold_needed: assert property (
        exc_valid && exc.stack_fault && !control_word[0] |=> top_hold)
        else $error("top hold missing");
    a_numeric_gate: assert property (
        exc_valid && !instr_is_arith && !exc.stack_fault |=> $stable(status_word[5:0]))
        else $error("numeric flag set");
    a_ctrl_load: assert property (
        instr_ack && $past(instr.op) == load_control_word_op
        |-> control_word == $past(instr.operand[15:0]))
        else $error("control word load wrong");
    a_store_status: assert property (
        store_valid && $past(instr.op) == store_status_word_op
        |-> store_data == {16'h0, $past(status_word)})
        else $error("stored status word wrong");
    a_store_ctrl: assert property (
        store_valid && $past(instr.op) == store_control_word_op
        |-> store_data == {16'h0, $past(control_word)})
        else $error("stored control word wrong");
    c_trap: cover property ($rose(instr_trap));
    c_hold: cover property (top_hold);
    c_irq: cover property ($rose(irq));
endmodule : feg_gate_monitor
bind feg_gate feg_gate_monitor u_feg_gate_monitor (
    .ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ack(instr_ack), .instr_trap(instr_trap), .instr_is_arith(instr_is_arith),
    .exc_valid(exc_valid), .exc(exc), .top_hold(top_hold), .store_valid(store_valid),
    .store_data(store_data), .status_word(status_word), .control_word(control_word),
    .irq(irq));
`default_nettype wire

/* bench/feg_pipe_model.sv */
// pipeline model: offers one instruction and holds it until answered
`default_nettype none
module feg_pipe_model
    import feg_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                go,
    input  wire feg_pkg::feg_instr_t go_instr,
    input  wire logic [2:0]          linger,
    input  wire logic                instr_ack,
    input  wire logic                instr_trap,
    output logic                     instr_valid,
    output feg_pkg::feg_instr_t      instr,
    output logic                     done,
    output logic                     trapped
);
    logic [2:0] cnt;
    // a trapped request stays up for linger cycles, as a slow handler would keep it
    always_ff @(posedge ref_clk) begin
        done <= 1'b0;
        if (rst) begin
            instr_valid <= 1'b0;
            instr       <= '0;
            trapped     <= 1'b0;
        end else if (!instr_valid && go) begin
            instr_valid <= 1'b1;
            instr       <= go_instr;
            trapped     <= 1'b0;
            cnt         <= linger;
        end else if (instr_valid && (instr_ack || (instr_trap && cnt == 3'h0))) begin
            instr_valid <= 1'b0;
            instr       <= feg_instr_t'(~instr); // released bus shows no stale value
            done        <= 1'b1;
            trapped     <= instr_trap;
        end else if (instr_trap) begin
            cnt <= cnt - 3'h1;
        end
    end
endmodule : feg_pipe_model
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench of the exception-gating unit
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import feg_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        go = 1'b0;
    feg_instr_t  go_instr = '0;
    feg_instr_t  instr;
    feg_exc_t    exc = '0;
    logic [2:0]  linger = 3'h0;
    logic        exc_valid = 1'b0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic        instr_valid, instr_ack, instr_trap, instr_is_arith, done, trapped;
    logic        top_hold, store_valid, avs_waitrequest, irq;
    logic [31:0] store_data, avs_readdata, last_store, rd;
    logic [15:0] status_word, control_word;
    int          errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    feg_gate u_feg_gate (
        .ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .instr_ack(instr_ack), .instr_trap(instr_trap), .instr_is_arith(instr_is_arith),
        .exc_valid(exc_valid), .exc(exc), .top_hold(top_hold), .store_valid(store_valid),
        .store_data(store_data), .status_word(status_word), .control_word(control_word),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    feg_pipe_model u_feg_pipe_model (
        .ref_clk(ref_clk), .rst(rst), .go(go), .go_instr(go_instr), .linger(linger),
        .instr_ack(instr_ack), .instr_trap(instr_trap), .instr_valid(instr_valid),
        .instr(instr), .done(done), .trapped(trapped));
    initial forever #2 ref_clk = ~ref_clk;
    // watchdog; keeps the last store pulse
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (store_valid === 1'b1) last_store <= store_data;
        if (cyc == 30000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic exp_arith(input feg_op_t op);
        return op inside {arith_generic_op, load_single_double_op, store_single_double_op,
                          truncating_int_store_pop_op};
    endfunction : exp_arith
    function automatic logic waits(input feg_op_t op, input logic nw);
        if (op inside {legacy_enable_irq_op, legacy_disable_irq_op, legacy_set_protmode_op})
            return 1'b0;
        return !(nw && op inside {store_status_word_op, store_control_word_op,
            clear_exceptions_op, initialize_op, full_state_save_op, store_environment_op});
    endfunction : waits
    // one instruction through the pipeline model, then let trap fall
    task automatic issue(input feg_op_t op, input logic nw, input logic [31:0] opd);
        go_instr <= {op, nw, opd};
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        while (done !== 1'b1) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
    endtask : issue
    // avalon master: request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic fire(input logic [5:0] f, input logic sf, input logic ov);
        exc_valid <= 1'b1;
        exc <= {f, sf, ov};
        @(posedge ref_clk);
        exc_valid <= 1'b0;
        exc <= ~{f, sf, ov};
        repeat (2) @(posedge ref_clk);
    endtask : fire
    initial begin
        logic [5:0] f, m;
        feg_op_t    op;
        feg_op_t    probe [9];
        probe = '{store_status_word_op, store_control_word_op, store_environment_op,
                  arith_generic_op, pending_exception_check_op, examine_op,
                  legacy_enable_irq_op, legacy_disable_irq_op, legacy_set_protmode_op};
        void'($urandom(62982));
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("control_word", 32'h3f, 32'(control_word));
        chk("status_word", 32'h0, 32'(status_word));
        // every code: its class, then, for all but the three legacy codes, numeric reports land only after arithmetic
        for (int i = 0; i < 31; i++) begin
            op = feg_op_t'(i);
            f = 6'($urandom()) & 6'h3e;
            linger = 3'($urandom());
            issue(op, 1'b1, 32'h3f);
            chk("class", 32'(exp_arith(op)), 32'(instr_is_arith));
            if (i < 28) fire(f, 1'b0, 1'b0);
            chk("status", 32'(exp_arith(op) ? f : 6'h0), 32'(status_word));
            chk("control_word", 32'h3f, 32'(control_word));
            bus(1'b1, OFS_STAT_WORD, 32'h7f, rd);
        end
        // unmask all, raise a stack overflow, then try both forms of each probe
        issue(load_control_word_op, 1'b0, 32'h0);
        issue(store_control_word_op, 1'b0, 32'h0);
        chk("store_cw", 32'h0, last_store);
        fire(6'h0, 1'b1, 1'b1);
        chk("status_word", 32'h2c1, 32'(status_word));
        for (int i = 0; i < 18; i++) begin
            issue(probe[i/2], i[0], 32'h0);
            chk("trapped", 32'(waits(probe[i/2], i[0])), 32'(trapped));
        end
        issue(clear_exceptions_op, 1'b1, 32'h0);
        issue(arith_generic_op, 1'b0, 32'h0);
        chk("trapped", 32'h0, 32'(trapped));
        fire(6'h0, 1'b1, 1'b0);
        chk("underflow", 32'h41, 32'(status_word & 16'h0241));
        // event interrupt: unmask, raise, clear; unmapped place and control word
        bus(1'b1, OFS_EVT_STATUS, 32'h7, rd);
        bus(1'b1, OFS_EVT_MASK, 32'h2, rd);
        fire(6'h0, 1'b1, 1'b1);
        bus(1'b0, OFS_EVT_STATUS, 32'h0, rd);
        chk("evt_status", 32'h2, rd);
        chk("irq", 32'h1, 32'(irq));
        bus(1'b1, OFS_EVT_STATUS, 32'h2, rd);
        bus(1'b0, 4'h2, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        chk("irq", 32'h0, 32'(irq));
        bus(1'b1, OFS_CTRL_WORD, 32'h15, rd);
        bus(1'b0, OFS_CTRL_WORD, 32'h0, rd);
        chk("ctrl_bus", 32'h15, rd);
        // random masks and flags: summary and gating follow the unmasked set
        for (int i = 0; i < 20; i++) begin
            m = 6'($urandom());
            f = 6'($urandom());
            bus(1'b1, OFS_STAT_WORD, 32'h7f, rd);
            issue(load_control_word_op, 1'b0, {26'h0, m});
            issue(arith_generic_op, 1'b0, 32'h0);
            fire(f, 1'b0, 1'b0);
            chk("status", 32'({|(f & ~m), 1'b0, f}), 32'(status_word[7:0]));
            issue(arith_generic_op, 1'b0, 32'h0);
            chk("trapped", 32'(|(f & ~m)), 32'(trapped));
        end
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire

/* hdl/feg_gate.sv */
// exception gating, classification and status/control words of the float stack unit
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`default_nettype none
// Notes on behaviour
// RULE_01: waiting instructions check pending unmasked exceptions before executing.
// RULE_02: waiting form of dual-form control ops checks first; non-waiting form never does.
// RULE_03: three legacy opcodes act as no-ops touching no internal state; here they set the legacy event flag and the class register.
// RULE_04: six exception classes detected, invalid split into stack fault and bad operand.
// RULE_05: each class has sticky status flag and control-word mask bit.
// RULE_06: summary flag set while any flagged exception is unmasked.
// RULE_07: stack-fault flag marks invalid operation caused by stack over/underflow.
// RULE_08: masks written by load-control/restores, read by store-control/saves.
// RULE_09: exception flags read by store-status and both save instructions.
// RULE_10: only arithmetic instructions raise operand-processing numeric exceptions.
// RULE_11: non-arithmetic instructions may still raise the stack fault exception.
// RULE_12: moves and extended loads/stores non-arithmetic; single/double arithmetic.
// RULE_13: abs, sign, clear, stack ptr, free, init, constants, exchange, examine: non-arith.
// RULE_14: truncating integer store-and-pop is arithmetic.
// RULE_15: check stalls only when a flag is set with its mask clear.
// RULE_16: invalid flag is status bit 0, its mask control bit 0.
// RULE_17: stack fault sets invalid flag, bit 6, and bit 9 one on overflow.
// RULE_18: unmasked invalid operation holds stack pointer and source operands.
module feg_gate
    import feg_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              instr_valid,
    input  wire feg_pkg::feg_instr_t instr,
    output logic                   instr_ack,
    output logic                   instr_trap,
    output logic                   instr_is_arith,
    input  wire logic              exc_valid,
    input  wire feg_pkg::feg_exc_t exc,
    output logic                   top_hold,
    output logic                   store_valid,
    output logic [31:0]            store_data,
    output logic [15:0]            status_word,
    output logic [15:0]            control_word,
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    output logic                   irq
);
    import feg_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACK  = 2'b01,
        ST_TRAP = 2'b10
    } feg_state_t;

    feg_state_t       state_reg;
    feg_state_t       state_next;
    logic [15:0]      sw_reg;
    logic [15:0]      sw_next;
    logic [15:0]      cw_reg;
    logic [15:0]      cw_next;
    logic [EVT_N-1:0] evt_reg;
    logic [EVT_N-1:0] evt_next;
    logic [EVT_N-1:0] evt_mask_reg;
    logic             cls_arith_reg;   // class of the last accepted instruction
    logic             ack_reg;
    logic             trap_reg;
    logic             hold_reg;
    logic             st_valid_reg;
    logic [31:0]      st_data_reg;
    logic [31:0]      rdata_reg;
    logic             wait_reg;
    logic             irq_reg;

    // class: moves, extended transfers and control codes are non-arithmetic;
    // the spare code counts as arithmetic, the cautious side
    wire logic is_arith = instr.op > legacy_set_protmode_op ||              // [RULE_13]
                          instr.op inside {arith_generic_op, load_single_double_op,
                                           store_single_double_op,         // [RULE_12]
                                           truncating_int_store_pop_op};   // [RULE_14]

    // gating decode
    wire logic [EXC_N-1:0] unmasked   = sw_reg[EXC_N-1:0] & ~cw_reg[EXC_N-1:0];
    wire logic             pending    = |unmasked;                        // [RULE_15]
    wire logic             is_legacy  = instr.op inside {legacy_enable_irq_op,
                                        legacy_disable_irq_op, legacy_set_protmode_op};
    wire logic             has_nowait = instr.op inside {store_status_word_op,
                                        store_control_word_op, clear_exceptions_op,
                                        initialize_op, full_state_save_op, store_environment_op};
    wire logic             skip_wait  = (has_nowait && instr.nowait) || is_legacy; // [RULE_02]
    wire logic             must_trap  = !skip_wait && pending;            // [RULE_01] [RULE_02]
    wire logic             take       = state_reg == ST_IDLE && instr_valid;
    wire logic             exec_fire  = take && !must_trap;
    wire logic             trap_fire  = take && must_trap;

    // effects of the accepted instruction; legacy codes decode only to legacy_hit
    wire logic do_init    = exec_fire && instr.op inside {initialize_op, full_state_save_op};
    wire logic do_ld_sw   = exec_fire && instr.op inside {full_state_restore_op,
                                                          extended_state_restore_op,
                                                          load_environment_op};
    wire logic do_ld_cw   = exec_fire && instr.op == load_control_word_op || do_ld_sw; // [RULE_08]
    wire logic do_clr     = exec_fire && instr.op == clear_exceptions_op;
    wire logic do_st_sw   = exec_fire && instr.op == store_status_word_op;   // [RULE_09]
    wire logic do_st_cw   = exec_fire && instr.op == store_control_word_op;  // [RULE_08]
    wire logic do_st_both = exec_fire && instr.op inside {full_state_save_op,
                                                          extended_state_save_op,
                                                          store_environment_op}; // [RULE_08] [RULE_09]
    wire logic legacy_hit = exec_fire && is_legacy;                          // [RULE_03]

    // exception report filtering by instruction class
    wire logic [EXC_N-1:0] num_flags = cls_arith_reg ? exc.flags : '0;       // [RULE_10]
    wire logic             stk       = exc_valid && exc.stack_fault;        // [RULE_11]
    wire logic [EXC_N-1:0] set_flags = exc_valid ? (num_flags |
                                       {{(EXC_N-1){1'b0}}, exc.stack_fault}) : '0; // [RULE_04]
    wire logic             inv_unmasked = set_flags[SW_IE_BIT] && !cw_reg[CW_IM_BIT];

    // bus decode
    wire logic        bus_req   = (avs_read || avs_write) && wait_reg;
    wire logic        bus_wr    = avs_write && !wait_reg;
    wire logic [31:0] be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire logic [31:0] wdata     = avs_writedata & be_mask;
    wire logic        wr_evt    = bus_wr && avs_address == OFS_EVT_STATUS;
    wire logic        wr_emask  = bus_wr && avs_address == OFS_EVT_MASK;
    wire logic        wr_cw     = bus_wr && avs_address == OFS_CTRL_WORD;
    wire logic        wr_sw     = bus_wr && avs_address == OFS_STAT_WORD;
    wire logic [31:0] rd_mux    =
        avs_address == OFS_EVT_STATUS ? {{(32-EVT_N){1'b0}}, evt_reg} :
        avs_address == OFS_EVT_MASK   ? {{(32-EVT_N){1'b0}}, evt_mask_reg} :
        avs_address == OFS_CTRL_WORD  ? {16'h0000, cw_reg} :
        avs_address == OFS_STAT_WORD  ? {16'h0000, sw_reg} : 32'h0000_0000;

    // gating sequence: accept, trap and hold, or settle after an ack
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (trap_fire) begin
                    state_next = ST_TRAP;
                end else if (exec_fire) begin
                    state_next = ST_ACK;
                end
            end
            ST_ACK:  state_next = ST_IDLE;
            // the pipeline withdraws the instruction to service the exception
            ST_TRAP: begin
                if (!instr_valid) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // status word: clears first, then hardware sets, so a set in the clear cycle survives
    always_comb begin
        sw_next = sw_reg;
        if (do_init) begin
            sw_next = SW_RESET;
        end else if (do_ld_sw) begin
            sw_next = instr.operand[31:16];
        end else if (do_clr) begin
            sw_next[SW_ES_BIT:0] = '0;
        end
        if (wr_sw) begin
            sw_next[SW_SF_BIT:0] = sw_next[SW_SF_BIT:0] & ~wdata[SW_SF_BIT:0];
        end
        sw_next[EXC_N-1:0] = sw_next[EXC_N-1:0] | set_flags;             // [RULE_05]
        if (stk) begin
            sw_next[SW_SF_BIT] = 1'b1;                                    // [RULE_07] [RULE_17]
            sw_next[SW_C1_BIT] = exc.stack_overflow;                      // [RULE_17]
        end
        sw_next[SW_ES_BIT] = |(sw_next[EXC_N-1:0] & ~cw_next[EXC_N-1:0]); // [RULE_06]
    end

    // control word: instruction loads take priority over a bus write in the same cycle
    always_comb begin
        cw_next = cw_reg;
        if (do_init) begin
            cw_next = CW_RESET;
        end else if (do_ld_cw) begin
            cw_next = instr.operand[15:0];                                // [RULE_08]
        end else if (wr_cw) begin
            cw_next = (cw_reg & ~be_mask[15:0]) | wdata[15:0];
        end
    end

    // event flags: set wins over a write-one clear
    always_comb begin
        evt_next = evt_reg;
        if (wr_evt) begin
            evt_next = evt_next & ~wdata[EVT_N-1:0];
        end
        evt_next[EVT_TRAP]   = evt_next[EVT_TRAP] | trap_fire;
        evt_next[EVT_EXC]    = evt_next[EVT_EXC] | (|set_flags);
        evt_next[EVT_LEGACY] = evt_next[EVT_LEGACY] | legacy_hit;
    end

    // state and word registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            sw_reg    <= SW_RESET;
            cw_reg    <= CW_RESET;
            evt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            sw_reg    <= sw_next;                                         // [RULE_16]
            cw_reg    <= cw_next;
            evt_reg   <= evt_next;
        end
    end

    // pipeline-facing handshake and class
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_reg       <= 1'b0;
            trap_reg      <= 1'b0;
            cls_arith_reg <= 1'b0;
        end else begin
            ack_reg  <= exec_fire;
            trap_reg <= trap_fire || (state_reg == ST_TRAP && instr_valid);
            if (exec_fire) begin
                cls_arith_reg <= is_arith;
            end
        end
    end

    // store results and stack-pointer hold
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_valid_reg <= 1'b0;
            st_data_reg  <= 32'h0000_0000;
            hold_reg     <= 1'b0;
        end else begin
            st_valid_reg <= do_st_sw || do_st_cw || do_st_both;
            if (do_st_sw) begin
                st_data_reg <= {16'h0000, sw_reg};
            end else if (do_st_cw) begin
                st_data_reg <= {16'h0000, cw_reg};
            end else if (do_st_both) begin
                st_data_reg <= {sw_reg, cw_reg};    // image taken before any reinit
            end
            hold_reg <= inv_unmasked;                                     // [RULE_18]
        end
    end

    // avalon slave: one wait cycle, then the transfer completes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wait_reg     <= 1'b1;
            rdata_reg    <= 32'h0000_0000;
            evt_mask_reg <= EVT_MASK_RESET;
            irq_reg      <= 1'b0;
        end else begin
            wait_reg <= !bus_req;
            if (bus_req) begin
                rdata_reg <= rd_mux;
            end
            if (wr_emask) begin
                evt_mask_reg <= wdata[EVT_N-1:0];
            end
            irq_reg <= |(evt_next & evt_mask_reg);
        end
    end

    assign instr_ack       = ack_reg;
    assign instr_trap      = trap_reg;
    assign instr_is_arith  = cls_arith_reg;
    assign top_hold        = hold_reg;
    assign store_valid     = st_valid_reg;
    assign store_data      = st_data_reg;
    assign status_word     = sw_reg;
    assign control_word    = cw_reg;
    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign irq             = irq_reg;
endmodule : feg_gate
`default_nettype wire

/* hdl/feg_pkg.sv */
// constants, instruction codes and carrier types of the exception-gating unit
`default_nettype none
package feg_pkg;
    localparam int          EXC_N       = 6;     // exception classes
    localparam int          SW_IE_BIT   = 0;     // invalid-operation flag
    localparam int          SW_SF_BIT   = 6;     // stack-fault flag
    localparam int          SW_ES_BIT   = 7;     // exception summary
    localparam int          SW_C1_BIT   = 9;     // condition bit one
    localparam int          CW_IM_BIT   = 0;     // invalid-operation mask
    localparam logic [15:0] CW_RESET    = 16'h003f;
    localparam logic [15:0] SW_RESET    = 16'h0000;
    // avalon byte offsets
    localparam logic [3:0]  OFS_EVT_STATUS = 4'h0;
    localparam logic [3:0]  OFS_EVT_MASK   = 4'h4;
    localparam logic [3:0]  OFS_CTRL_WORD  = 4'h8;
    localparam logic [3:0]  OFS_STAT_WORD  = 4'hc;
    // event bits
    localparam int          EVT_N       = 3;
    localparam int          EVT_TRAP    = 0;
    localparam int          EVT_EXC     = 1;
    localparam int          EVT_LEGACY  = 2;
    localparam logic [EVT_N-1:0] EVT_MASK_RESET = 3'h0;

    typedef enum logic [4:0] {
        arith_generic_op             = 5'h00,
        load_single_double_op        = 5'h01,
        store_single_double_op       = 5'h02,
        truncating_int_store_pop_op  = 5'h03,
        move_reg_op                  = 5'h04,
        load_extended_op             = 5'h05,
        store_extended_op            = 5'h06,
        abs_value_op                 = 5'h07,
        change_sign_op               = 5'h08,
        clear_exceptions_op          = 5'h09,
        stack_ptr_inc_op             = 5'h0a,
        stack_ptr_dec_op             = 5'h0b,
        free_reg_op                  = 5'h0c,
        initialize_op                = 5'h0d,
        load_constant_op             = 5'h0e,
        exchange_op                  = 5'h0f,
        examine_op                   = 5'h10,
        no_operation_op              = 5'h11,
        pending_exception_check_op   = 5'h12,
        store_status_word_op         = 5'h13,
        store_control_word_op        = 5'h14,
        load_control_word_op         = 5'h15,
        full_state_restore_op        = 5'h16,
        extended_state_restore_op    = 5'h17,
        full_state_save_op           = 5'h18,
        extended_state_save_op       = 5'h19,
        store_environment_op         = 5'h1a,
        load_environment_op          = 5'h1b,
        legacy_enable_irq_op         = 5'h1c,
        legacy_disable_irq_op        = 5'h1d,
        legacy_set_protmode_op       = 5'h1e
    } feg_op_t;

    typedef struct packed {
        feg_op_t     op;
        logic        nowait;   // selects the non-waiting form where one exists
        logic [31:0] operand;  // [31:16] status image, [15:0] control image
    } feg_instr_t;

    // flags order: 0 invalid, 1 denormal, 2 divide-by-zero, 3 overflow, 4 underflow, 5 inexact
    typedef struct packed {
        logic [EXC_N-1:0] flags;
        logic             stack_fault;
        logic             stack_overflow;
    } feg_exc_t;
endpackage : feg_pkg
`default_nettype wire
